// [gpiox_pin.sv]
// gpiox_pin: output mux of one port pin
// assumes select inputs synchronous to aclk, built from top-module flip-flops and inputs
`timescale 1ns/1ps
module gpiox_pin
	import gpiox_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic dir_in,
	input  wire logic latch_bit,
	input  wire logic slave_rd,
	input  wire logic pwm_sel,
	input  wire logic pwm_bit,
	input  wire logic pwm_tri,
	output logic      pin_out,
	output logic      pin_oe
);
	logic next_out;
	logic next_oe;

	always_comb begin
		next_out = latch_bit;
		next_oe = ~dir_in;
		if (slave_rd) begin
			next_oe = 1'b1;
		end
		if (pwm_sel) begin
			next_out = pwm_bit;
			next_oe = ~dir_in & ~pwm_tri;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
		end else begin
			pin_out <= next_out;
			pin_oe <= next_oe;
		end
	end
endmodule

// [gpiox_pins_model.sv]
// gpiox_pins_model: board wiring on the eight port pins
// assumes the bench chooses which pins the board drives and with what
`timescale 1ns/1ps
module gpiox_pins_model (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext_oe,
	input  wire logic [7:0] ext_val,
	output logic [7:0]      pin_in
);
	// a floating pin reads the inverse of its drive, so stale data shows
	always_comb
		for (int i = 0; i < 8; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i]
				: (ext_oe[i] ? ext_val[i] : ~pin_out[i]);
endmodule

// [gpiox_pkg.sv]
// gpiox_pkg: register map, field positions and reset values of the port
// assumes a 32-bit AXI4-Lite register bus, byte addresses, word aligned
package gpiox_pkg;
	localparam int unsigned GPIOX_ADDR_W = 5;
	localparam logic [4:0] GPIOX_OFS_PINS = 5'h00;
	localparam logic [4:0] GPIOX_OFS_LATCH = 5'h04;
	localparam logic [4:0] GPIOX_OFS_DIR = 5'h08;
	localparam logic [4:0] GPIOX_OFS_SPSC = 5'h0c;
	localparam logic [4:0] GPIOX_OFS_PWMCC = 5'h10;
	localparam logic [4:0] GPIOX_OFS_PWMSTAT = 5'h14;
	localparam logic [7:0] GPIOX_RST_DIR = 8'hff;
	localparam logic [7:0] GPIOX_RST_LATCH = 8'h00;
	localparam logic [7:0] GPIOX_RST_PWMCC = 8'h00;
	localparam logic [7:0] GPIOX_RST_PWMST = 8'h00;
	localparam logic [2:0] GPIOX_RST_NDIR = 3'h7;
	localparam int unsigned GPIOX_SPSC_IBF = 7;
	localparam int unsigned GPIOX_SPSC_OBF = 6;
	localparam int unsigned GPIOX_SPSC_INPUT_OVERFLOW_FLAG = 5;
	localparam int unsigned GPIOX_SPSC_MODE = 4;
	localparam int unsigned GPIOX_PWM_MODE_HI = 7;
	localparam int unsigned GPIOX_PWM_MODE_LO = 6;
	localparam int unsigned GPIOX_PWM_FIRST_PIN = 5;
	localparam int unsigned GPIOX_PWMST_TRI = 0;
	localparam logic [1:0] GPIOX_RESP_OKAY = 2'h0;
	localparam logic [1:0] GPIOX_RESP_SLVERR = 2'h2;
endpackage

// [gpiox_port.sv]
// gpiox_port: eight-bit bidirectional port with slave-port and pwm muxing
// assumes pins, slave strobes and pwm signals synchronous to aclk
// Summary of operation
// - eight pins, one bit per pin in direction, latch and pin registers.
// - a direction bit of one turns the pin driver off, pin is input.
// - a direction bit of zero drives the latch bit onto the pin.
// - the latch is mapped and reads back the latch, not the pins.
// - after reset every direction bit is one, all pins inputs.
// - the mode-select bit 4 of the slave status register makes a cpu port.
// - mode-select one means slave port, zero means general purpose io.
// - dual or quad pwm mode disables the slave port whatever mode-select.
// - in slave mode an external read drives every pin not held by pwm from the latch.
// - in slave mode the pins take external write data as inputs.
// - pins 5 to 7 carry pwm b, c, d when enabled, over all other data.
// - a pwm output drives its pin only when its direction bit is zero.
// - pwm pins may float while a pwm shutdown event is active.
// - bit 3 of the slave status register reads as zero.
// - slave status holds ibf, obf, input_overflow_flag, mode, zero, three dir bits.
`timescale 1ns/1ps
module gpiox_port
	import gpiox_pkg::*;
(
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [GPIOX_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [GPIOX_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic [7:0]              pin_in,
	output logic [7:0]                   pin_out,
	output logic [7:0]                   pin_oe,
	input  wire logic                    slave_read_active,
	input  wire logic                    slave_write_strobe,
	input  wire logic                    input_full_flag,
	input  wire logic                    output_full_flag,
	input  wire logic                    input_overflow_flag,
	input  wire logic                    pwm_channel_b_out,
	input  wire logic                    pwm_channel_c_out,
	input  wire logic                    pwm_channel_d_out,
	input  wire logic [2:0]              pwm_channel_enable,
	input  wire logic                    pwm_shutdown_active,
	output logic                         parallel_slave_port_active,
	output logic [7:0]                   slave_write_data,
	output logic                         slave_overflow_clear,
	output logic [2:0]                   neighbour_dir
);
	logic [7:0]              port_direction;
	logic [7:0]              port_output_latch;
	logic [7:0]              pwm_capture_control;
	logic                    slave_mode_select;
	logic                    shutdown_tristate;
	logic [7:0]              pin_meta;
	logic [7:0]              pin_sync;
	logic [GPIOX_ADDR_W-1:0] aw_addr;
	logic                    aw_held;
	logic [31:0]             w_data;
	logic [3:0]              w_strb;
	logic                    w_held;
	logic                    do_write;
	logic                    slave_enabled;
	logic                    pwm_multi;
	logic [31:0]             next_rdata;
	logic                    next_rerr;
	logic                    wr_latch;
	logic                    wr_dir;
	logic                    wr_spsc;
	logic                    wr_pwmcc;
	logic                    wr_pwmst;
	logic                    next_bad;
	logic [2:0]              pwm_bits;
	logic [7:0]              spsc_view;
	logic                    slave_drive;
	logic                    pwm_float;

	// write channel: address and data taken in either order
	assign do_write = aw_held & w_held & ~s_axi_bvalid;

	// ready beats high and low while idle and stays low while a response
	// waits, so a second write cannot slip in ahead of the first answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid & s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= ~w_held & ~s_axi_wready & ~s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid & s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// a cleared low strobe writes nothing yet is still answered
	always_comb begin
		wr_latch = 1'b0;
		wr_dir = 1'b0;
		wr_spsc = 1'b0;
		wr_pwmcc = 1'b0;
		wr_pwmst = 1'b0;
		next_bad = 1'b0;
		unique case (aw_addr)
			GPIOX_OFS_PINS: wr_latch = 1'b1;
			GPIOX_OFS_LATCH: wr_latch = 1'b1;
			GPIOX_OFS_DIR: wr_dir = 1'b1;
			GPIOX_OFS_SPSC: wr_spsc = 1'b1;
			GPIOX_OFS_PWMCC: wr_pwmcc = 1'b1;
			GPIOX_OFS_PWMSTAT: wr_pwmst = 1'b1;
			default: next_bad = 1'b1;
		endcase
		if (!do_write || !w_strb[0]) begin
			wr_latch = 1'b0;
			wr_dir = 1'b0;
			wr_spsc = 1'b0;
			wr_pwmcc = 1'b0;
			wr_pwmst = 1'b0;
		end
	end

	// response stands until taken; the write lands at the edge it rises
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= GPIOX_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= next_bad ? GPIOX_RESP_SLVERR : GPIOX_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// only the low byte of the word is kept; upper bytes are ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_output_latch <= GPIOX_RST_LATCH;
		end else if (wr_latch) begin
			port_output_latch <= w_data[7:0];
		end
	end

	// all ones at reset keeps every pin an input until software decides
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_direction <= GPIOX_RST_DIR;
		end else if (wr_dir) begin
			port_direction <= w_data[7:0];
		end
	end

	// flags are owned by the slave port handshake; only input_overflow_flag clear leaves here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slave_overflow_clear <= 1'b0;
		end else begin
			slave_overflow_clear <= wr_spsc & ~w_data[GPIOX_SPSC_INPUT_OVERFLOW_FLAG];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slave_mode_select <= 1'b0;
			neighbour_dir <= GPIOX_RST_NDIR;
		end else if (wr_spsc) begin
			slave_mode_select <= w_data[GPIOX_SPSC_MODE];
			neighbour_dir <= w_data[2:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwm_capture_control <= GPIOX_RST_PWMCC;
			shutdown_tristate <= GPIOX_RST_PWMST[GPIOX_PWMST_TRI];
		end else begin
			if (wr_pwmcc) begin
				pwm_capture_control <= w_data[7:0];
			end
			if (wr_pwmst) begin
				shutdown_tristate <= w_data[GPIOX_PWMST_TRI];
			end
		end
	end

	// every mode but single output drives two or four pins and takes the port
	always_comb begin
		pwm_multi = 1'b0;
		unique case ({pwm_capture_control[GPIOX_PWM_MODE_HI],
			pwm_capture_control[GPIOX_PWM_MODE_LO]})
			2'b00: pwm_multi = 1'b0;
			2'b01: pwm_multi = 1'b1;
			2'b10: pwm_multi = 1'b1;
			2'b11: pwm_multi = 1'b1;
		endcase
	end
	assign slave_enabled = slave_mode_select & ~pwm_multi;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			parallel_slave_port_active <= 1'b0;
		end else begin
			parallel_slave_port_active <= slave_enabled;
		end
	end

	// two-stage synchroniser; pin_meta is read only by pin_sync
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	// external write data comes off the synchronised pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slave_write_data <= '0;
		end else if (slave_enabled & slave_write_strobe) begin
			slave_write_data <= pin_sync;
		end
	end

	// status view; the three flags belong to the slave port handshake
	always_comb begin
		spsc_view = 8'h00;
		spsc_view[GPIOX_SPSC_IBF] = input_full_flag;
		spsc_view[GPIOX_SPSC_OBF] = output_full_flag;
		spsc_view[GPIOX_SPSC_INPUT_OVERFLOW_FLAG] = input_overflow_flag;
		spsc_view[GPIOX_SPSC_MODE] = slave_mode_select;
		spsc_view[2:0] = neighbour_dir;
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rerr = 1'b0;
		unique case (s_axi_araddr)
			GPIOX_OFS_PINS: next_rdata[7:0] = pin_sync;
			GPIOX_OFS_LATCH: next_rdata[7:0] = port_output_latch;
			GPIOX_OFS_DIR: next_rdata[7:0] = port_direction;
			GPIOX_OFS_SPSC: next_rdata[7:0] = spsc_view;
			GPIOX_OFS_PWMCC: next_rdata[7:0] = pwm_capture_control;
			GPIOX_OFS_PWMSTAT: next_rdata[GPIOX_PWMST_TRI] = shutdown_tristate;
			default: next_rerr = 1'b1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= GPIOX_RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rerr ? GPIOX_RESP_SLVERR : GPIOX_RESP_OKAY;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	assign pwm_bits = {pwm_channel_d_out, pwm_channel_c_out,
		pwm_channel_b_out};

	// a slave read drives every pin that pwm does not hold
	assign slave_drive = slave_enabled & slave_read_active;
	assign pwm_float = shutdown_tristate & pwm_shutdown_active;

	// one mux per pin; top three pins also see a pwm channel
	generate
		for (genvar i = 0; i < 8; i++) begin : g_pin
			logic psel;
			logic pbit;
			logic dir_eff;
			if (i >= GPIOX_PWM_FIRST_PIN) begin : g_pwm
				assign psel = pwm_channel_enable[i-GPIOX_PWM_FIRST_PIN];
				assign pbit = pwm_bits[i-GPIOX_PWM_FIRST_PIN];
			end else begin : g_plain
				assign psel = 1'b0;
				assign pbit = 1'b0;
			end
			// slave mode frees the pin for incoming data unless pwm holds it
			assign dir_eff = port_direction[i]
				| (slave_enabled & ~psel);
			gpiox_pin u_pin (
				.aclk      (aclk),
				.aresetn   (aresetn),
				.dir_in    (dir_eff),
				.latch_bit (port_output_latch[i]),
				.slave_rd  (slave_drive),
				.pwm_sel   (psel),
				.pwm_bit   (pbit),
				.pwm_tri   (pwm_float),
				.pin_out   (pin_out[i]),
				.pin_oe    (pin_oe[i])
			);
		end
	endgenerate
endmodule

// [gpiox_port_bench.sv]
// gpiox_port_bench: register-level tests of gpiox_port
// assumes gpiox_pins_model closes the pins and the monitor is bound
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("CHECK FAILED %s exp %h got %h", n, e, g); \
	end \
end
module gpiox_port_bench
	import gpiox_pkg::*;
;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  pin_in, pin_out, pin_oe, slave_write_data, ext_oe, ext_val;
	logic        slave_read_active, slave_write_strobe, input_full_flag;
	logic        output_full_flag, input_overflow_flag, pwm_channel_b_out;
	logic        pwm_channel_c_out, pwm_channel_d_out, pwm_shutdown_active;
	logic        parallel_slave_port_active, slave_overflow_clear;
	logic [2:0]  pwm_channel_enable, neighbour_dir;
	int          err_total, cmp_count;

	gpiox_port i_gpiox_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
		.pin_oe, .slave_read_active, .slave_write_strobe, .input_full_flag,
		.output_full_flag, .input_overflow_flag, .pwm_channel_b_out,
		.pwm_channel_c_out, .pwm_channel_d_out, .pwm_channel_enable,
		.pwm_shutdown_active, .parallel_slave_port_active,
		.slave_write_data, .slave_overflow_clear, .neighbour_dir);
	gpiox_pins_model i_gpiox_pins_model (.pin_out, .pin_oe, .ext_oe,
		.ext_val, .pin_in);

	always #10 aclk = ~aclk;

	task automatic finish_test();
		if (err_total == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		`CHK("bresp", er, s_axi_bresp)
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] e,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		`CHK("rresp", er, s_axi_rresp)
		if (er == GPIOX_RESP_OKAY)
			`CHK("rdata", {24'h0, e}, s_axi_rdata)
	endtask

	initial begin
		#200000;
		err_total++;
		finish_test();
	end

	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, slave_read_active, slave_write_strobe} = '0;
		{pwm_channel_enable, pwm_shutdown_active, output_full_flag} = '0;
		{pwm_channel_b_out, pwm_channel_c_out, pwm_channel_d_out} = '0;
		{input_full_flag, input_overflow_flag} = 2'h3;
		s_axi_wstrb = 4'hf;
		ext_oe = 8'hff;
		ext_val = 8'h00;
		err_total = 0;
		cmp_count = 0;
		tick(6);
		aresetn <= 1'b1;
		`CHK("oe_rst", 8'h00, pin_oe)
		rd(GPIOX_OFS_DIR, 8'hff, GPIOX_RESP_OKAY);
		rd(GPIOX_OFS_SPSC, 8'ha7, GPIOX_RESP_OKAY);
		wr(GPIOX_OFS_LATCH, 8'h5a, GPIOX_RESP_OKAY);
		wr(GPIOX_OFS_DIR, 8'h0f, GPIOX_RESP_OKAY);
		ext_oe <= 8'h0f;
		ext_val <= 8'ha5;
		tick(3);
		`CHK("oe", 8'hf0, pin_oe)
		`CHK("out", 8'h50, pin_out & pin_oe)
		rd(GPIOX_OFS_LATCH, 8'h5a, GPIOX_RESP_OKAY);
		rd(GPIOX_OFS_PINS, 8'h55, GPIOX_RESP_OKAY);
		wr(GPIOX_OFS_PINS, 8'h3c, GPIOX_RESP_OKAY);
		rd(GPIOX_OFS_LATCH, 8'h3c, GPIOX_RESP_OKAY);
		s_axi_wstrb <= 4'h0;
		wr(GPIOX_OFS_LATCH, 8'hff, GPIOX_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(GPIOX_OFS_LATCH, 8'h3c, GPIOX_RESP_OKAY);
		wr(5'h18, 8'hff, GPIOX_RESP_SLVERR);
		rd(5'h1c, 8'h00, GPIOX_RESP_SLVERR);
		wr(GPIOX_OFS_SPSC, 8'h1d, GPIOX_RESP_OKAY);
		`CHK("ovf_clr", 1'b1, slave_overflow_clear)
		`CHK("ndir", 3'h5, neighbour_dir)
		tick(2);
		`CHK("psp_on", 1'b1, parallel_slave_port_active)
		`CHK("ovf_idle", 1'b0, slave_overflow_clear)
		`CHK("psp_idle", 8'h00, pin_oe)
		slave_read_active <= 1'b1;
		tick(3);
		`CHK("rd_oe", 8'hff, pin_oe)
		`CHK("rd_out", 8'h3c, pin_out)
		slave_read_active <= 1'b0;
		wr(GPIOX_OFS_DIR, 8'h00, GPIOX_RESP_OKAY);
		ext_oe <= 8'hff;
		ext_val <= 8'hc3;
		tick(4);
		`CHK("psp_in", 8'h00, pin_oe)
		slave_write_strobe <= 1'b1;
		tick(1);
		slave_write_strobe <= 1'b0;
		tick(2);
		`CHK("wdata", 8'hc3, slave_write_data)
		wr(GPIOX_OFS_PWMCC, 8'h40, GPIOX_RESP_OKAY);
		tick(2);
		`CHK("psp_off", 1'b0, parallel_slave_port_active)
		rd(GPIOX_OFS_SPSC, 8'hb5, GPIOX_RESP_OKAY);
		wr(GPIOX_OFS_DIR, 8'h1f, GPIOX_RESP_OKAY);
		pwm_channel_enable <= 3'h7;
		pwm_channel_c_out <= 1'b1;
		pwm_channel_d_out <= 1'b1;
		tick(3);
		`CHK("pwm", 8'hc0, pin_out & 8'he0)
		`CHK("pwm_oe", 8'he0, pin_oe & 8'he0)
		wr(GPIOX_OFS_DIR, 8'h3f, GPIOX_RESP_OKAY);
		tick(3);
		`CHK("pwm_dir", 8'hc0, pin_oe & 8'he0)
		wr(GPIOX_OFS_PWMSTAT, 8'h01, GPIOX_RESP_OKAY);
		pwm_shutdown_active <= 1'b1;
		tick(3);
		`CHK("shutdown", 8'h00, pin_oe & 8'he0)
		finish_test();
	end
endmodule

// [gpiox_port_monitor.sv]
// gpiox_port_monitor: port-level assertions for gpiox_port
// assumes the bind at the foot reaches every gpiox_port instance
`timescale 1ns/1ps
module gpiox_port_monitor
	import gpiox_pkg::*;
(
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire logic [GPIOX_ADDR_W-1:0] s_axi_awaddr,
	input wire logic                    s_axi_awvalid,
	input wire logic                    s_axi_awready,
	input wire logic [1:0]              s_axi_bresp,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_bready,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic [31:0]             s_axi_rdata,
	input wire logic                    s_axi_rvalid,
	input wire logic                    s_axi_rready,
	input wire logic [7:0]              pin_out,
	input wire logic [7:0]              pin_oe,
	input wire logic                    slave_read_active,
	input wire logic                    pwm_channel_b_out,
	input wire logic [2:0]              pwm_channel_enable,
	input wire logic                    parallel_slave_port_active
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// reset itself is the cause here, so it must not disable the check
	rst_quiet_a: assert property (disable iff (1'b0)
		!aresetn |=> pin_oe == 8'h00 && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not quiet after reset");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	upper_zero_a: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
	bad_addr_a: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_awaddr > GPIOX_OFS_PWMSTAT
		|-> ##[1:8] s_axi_bvalid && s_axi_bresp == GPIOX_RESP_SLVERR)
		else $error("unmapped write not refused");
	one_write_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while response pending");
	slave_read_a: assert property (
		$past(slave_read_active && parallel_slave_port_active)
		|-> pin_oe[4:0] == 5'h1f) else $error("slave read not driven");
	pwm_b_a: assert property ($past(pwm_channel_enable[0])
		&& pin_oe[5] |-> pin_out[5] == $past(pwm_channel_b_out))
		else $error("pwm b not on pin 5");
	slave_idle_a: assert property (
		$past(parallel_slave_port_active && !slave_read_active)
		&& parallel_slave_port_active |-> pin_oe[4:0] == 5'h00)
		else $error("slave port idle yet pins driven");
endmodule

bind gpiox_port gpiox_port_monitor i_mon (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .pin_out, .pin_oe, .slave_read_active,
	.pwm_channel_b_out, .pwm_channel_enable, .parallel_slave_port_active);
